// ---- pkg/fpec_map.svh ----
`ifndef FPEC_MAP_SVH
`define FPEC_MAP_SVH
// Overview of operation
// - bit 7 reads 1 while protect pin low
// - bit 6 unlock; writes allowed with bit 7
// - unlock low blocks setting other bits
// - bit 5 erase setup when unlocked
// - bit 4 program setup when unlocked
// - bit 3 erase verify when unlocked
// - bit 2 program verify when unlocked
// - bit 1 erase needs erase setup too
// - bit 0 program needs program setup too
// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define FPEC_CTL_ADDR    4'h0
`define FPEC_SEL1_ADDR   4'h1
`define FPEC_SEL2_ADDR   4'h2
`define FPEC_CTL_RST     8'h00
`define FPEC_SEL_RST     8'h00
// ----------------------------------------------------------------
// field positions of the control register
// ----------------------------------------------------------------
`define FPEC_B_PIN       7
`define FPEC_B_UNLOCK    6
`define FPEC_B_WPREP     5
`define FPEC_B_PPREP     4
`define FPEC_B_WCHK      3
`define FPEC_B_PCHK      2
`define FPEC_B_WGO       1
`define FPEC_B_PGO       0
`endif

// ---- pkg/fpec_pkg.sv ----
package fpec_pkg;
	// ----------------------------------------------------------------
	// flash control outputs bundled
	// ----------------------------------------------------------------
	typedef struct packed {
		logic erase_setup;  // erase setup state
		logic prog_setup;   // program setup state
		logic erase_verify; // erase verify mode
		logic prog_verify;  // program verify mode
		logic erase_go;     // erase mode
		logic prog_go;      // program mode
	} fpec_flash_s;
	// whole module state
	typedef struct packed {
		logic [6:0]  ctl;       // bits 6..0 of control
		logic [7:0]  sel1;      // block select one
		logic [7:0]  sel2;      // block select two
		logic        pin_lvl;   // mirrored pin level
		logic        ack;       // bus answer pending
		logic [31:0] rdata;     // read data
	} fpec_state_s;
endpackage : fpec_pkg

// ---- hdl/fpec_top.sv ----
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "fpec_map.svh"
module fpec_top (
	input  wire logic        core_clk_i,           // 200 MHz clock
	input  wire logic        sys_rst_i,            // async reset, high
	input  wire logic        write_protect_pin_i,  // protect pin, low allows writes
	input  wire logic [3:0]  avs_address_i,        // word address
	input  wire logic        avs_read_i,           // read strobe
	input  wire logic        avs_write_i,          // write strobe
	input  wire logic [31:0] avs_writedata_i,      // write data
	input  wire logic [3:0]  avs_byteenable_i,     // byte enables
	output logic      [31:0] avs_readdata_o,       // read data
	output logic             avs_waitrequest_o,    // stall
	output fpec_pkg::fpec_flash_s flash_ctl_o,     // flash control levels
	output logic [7:0]       block_sel_one_o,      // block select one
	output logic [7:0]       block_sel_two_o       // block select two
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	fpec_pkg::fpec_state_s s_q;  // registered state
	fpec_pkg::fpec_state_s s_d;  // next state
	logic                  req;  // new access this cycle
	logic                  wen;  // write accepted
	logic [7:0]            wb;   // low byte written
	logic                  lvl;  // write allowed by pin level
	logic                  unl;  // unlock currently set
	logic [7:0]            ctl_rd; // readable control byte

	assign req = (avs_read_i | avs_write_i) & ~s_q.ack;
	// a write lands only at the edge where waitrequest is seen low, so the
	// master and the register agree on the single edge that commits it
	assign wen = avs_write_i & s_q.ack & avs_byteenable_i[0];
	assign wb  = avs_writedata_i[7:0];
	assign lvl = s_q.pin_lvl;
	assign unl = s_q.ctl[`FPEC_B_UNLOCK];
	assign ctl_rd = {s_q.pin_lvl, s_q.ctl};

	// ----------------------------------------------------------------
	// notes for whoever drives this block
	// ----------------------------------------------------------------
	// every access takes two cycles: the request is seen with
	// waitrequest high, the answer stands one cycle later with
	// waitrequest low, and a write is committed at that answer edge.
	// read data is captured when the request is first seen, so a read
	// returns the state of the cycle before waitrequest goes low.
	// only byte lane zero carries register bits; a write with that lane
	// disabled is silently dropped rather than stalled, which keeps the
	// answer timing fixed at the cost of no error report.
	// gating works from the top down: the pin level gates the unlock,
	// the unlock gates every setup and verify bit and both select
	// registers, and each setup bit gates its own go bit.
	// losing the unlock or a setup bit clears what is beneath it in the same
	// cycle and losing the pin level one cycle later, so the flash never
	// sees a go level without its setup level.
	// a go bit can only be set by a write that finds its setup bit
	// already set; setting both in one write is refused on purpose so
	// that software must pass through the setup state first.
	// the pin is taken as synchronous; a raw board pin needs a
	// synchroniser in front of this block.
	// unmapped offsets read as zero and ignore writes.
	// the unlock itself can only be set while the pin allows writes.

	// ----------------------------------------------------------------
	// next state; every access answers one cycle after it is seen
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.pin_lvl = ~write_protect_pin_i;
		s_d.ack = req;                                   // one wait state
		if (req) begin
			unique case (avs_address_i)
				`FPEC_CTL_ADDR:  s_d.rdata = {24'h000000, ctl_rd};
				`FPEC_SEL1_ADDR: s_d.rdata = {24'h000000, s_q.sel1};
				`FPEC_SEL2_ADDR: s_d.rdata = {24'h000000, s_q.sel2};
				default:         s_d.rdata = 32'h00000000; // unmapped reads zero
			endcase
		end
		if (wen && avs_address_i == `FPEC_CTL_ADDR) begin
			// unlock only sticks with the pin allowing writes
			s_d.ctl[`FPEC_B_UNLOCK] = wb[`FPEC_B_UNLOCK] & lvl;
			// gated bits: clearing always works, setting needs gates
			s_d.ctl[`FPEC_B_WPREP] = wb[`FPEC_B_WPREP] & lvl & unl;
			s_d.ctl[`FPEC_B_PPREP] = wb[`FPEC_B_PPREP] & lvl & unl;
			s_d.ctl[`FPEC_B_WCHK]  = wb[`FPEC_B_WCHK] & lvl & unl;
			s_d.ctl[`FPEC_B_PCHK]  = wb[`FPEC_B_PCHK] & lvl & unl;
			s_d.ctl[`FPEC_B_WGO]   = wb[`FPEC_B_WGO] & lvl & unl
				& s_q.ctl[`FPEC_B_WPREP];
			s_d.ctl[`FPEC_B_PGO]   = wb[`FPEC_B_PGO] & lvl & unl
				& s_q.ctl[`FPEC_B_PPREP];
		end
		if (wen && avs_address_i == `FPEC_SEL1_ADDR) begin
			s_d.sel1 = wb & {8{unl & lvl}};
		end
		if (wen && avs_address_i == `FPEC_SEL2_ADDR) begin
			s_d.sel2 = wb & {8{unl & lvl}};
		end
		// losing the pin or unlock drops everything gated beneath it
		if (!lvl) begin
			s_d.ctl = 7'h00;
		end
		if (!s_d.ctl[`FPEC_B_UNLOCK]) begin
			s_d.ctl[5:0] = 6'h00;
			s_d.sel1 = 8'h00;
			s_d.sel2 = 8'h00;
		end
		if (!s_d.ctl[`FPEC_B_WPREP]) s_d.ctl[`FPEC_B_WGO] = 1'b0;
		if (!s_d.ctl[`FPEC_B_PPREP]) s_d.ctl[`FPEC_B_PGO] = 1'b0;
	end

	// ----------------------------------------------------------------
	// register the state
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs, straight from flops
	// ----------------------------------------------------------------
	assign avs_readdata_o    = s_q.rdata;
	assign avs_waitrequest_o = ~s_q.ack;
	assign flash_ctl_o.erase_setup  = s_q.ctl[`FPEC_B_WPREP];
	assign flash_ctl_o.prog_setup   = s_q.ctl[`FPEC_B_PPREP];
	assign flash_ctl_o.erase_verify = s_q.ctl[`FPEC_B_WCHK];
	assign flash_ctl_o.prog_verify  = s_q.ctl[`FPEC_B_PCHK];
	assign flash_ctl_o.erase_go     = s_q.ctl[`FPEC_B_WGO];
	assign flash_ctl_o.prog_go      = s_q.ctl[`FPEC_B_PGO];
	assign block_sel_one_o   = s_q.sel1;
	assign block_sel_two_o   = s_q.sel2;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	sequence ctl_wr_s;
		wen && avs_address_i == `FPEC_CTL_ADDR;
	endsequence

	pin_mirror_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!$past(sys_rst_i) |-> s_q.pin_lvl == !$past(write_protect_pin_i))
		else $error("pin level mirror wrong");
	unlock_gate_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!s_q.pin_lvl |=> !s_q.ctl[`FPEC_B_UNLOCK])
		else $error("unlock set with pin high");
	locked_clear_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!s_q.ctl[`FPEC_B_UNLOCK] |-> s_q.ctl[5:0] == 6'h00 && s_q.sel1 == 8'h00)
		else $error("bits set while locked");
	wprep_set_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 (wb[5] && lvl && unl && wb[6] && !write_protect_pin_i)
		|=> s_q.ctl[`FPEC_B_WPREP])
		else $error("erase setup not entered");
	pprep_clr_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 !wb[4] |=> !s_q.ctl[`FPEC_B_PPREP])
		else $error("program setup not left");
	wchk_set_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(s_q.ctl[`FPEC_B_WCHK]) |-> $past(lvl && unl))
		else $error("erase verify set while gated");
	pchk_set_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(s_q.ctl[`FPEC_B_PCHK]) |-> $past(lvl && unl))
		else $error("program verify set while gated");
	erase_gate_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		s_q.ctl[`FPEC_B_WGO] |-> s_q.ctl[`FPEC_B_WPREP] && s_q.ctl[`FPEC_B_UNLOCK])
		else $error("erase without setup");
	prog_gate_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(s_q.ctl[`FPEC_B_PGO]) |-> $past(s_q.ctl[`FPEC_B_PPREP]))
		else $error("program without setup");
	refused_zero_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 !unl |=> s_q.ctl[5:0] == 6'h00)
		else $error("refused set took effect");

	// ----------------------------------------------------------------
	// bus handshake and read data checks
	// ----------------------------------------------------------------
	// a request seen while idle is answered exactly one cycle later
	sequence bus_req_s;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence

	// a control write that finds both the pin and the unlock set and writes the unlock bit as one
	sequence ctl_open_s;
		ctl_wr_s ##0 (lvl && unl && wb[`FPEC_B_UNLOCK]);
	endsequence

	// the answer comes after one wait state, never later
	answer_time_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		bus_req_s |=> !avs_waitrequest_o)
		else $error("answer not one cycle after request");

	// the answer stands for a single cycle only
	wait_pulse_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer held too long");

	// register bytes sit in the low lane; upper lanes always read zero
	rdata_upper_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		avs_readdata_o[31:8] == 24'h000000)
		else $error("upper read lanes not zero");

	// unmapped offsets read back zero
	unmapped_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		bus_req_s ##0 (avs_address_i > `FPEC_SEL2_ADDR) |=> avs_readdata_o == 32'h00000000)
		else $error("unmapped read not zero");

	// the control read shows pin level on top of the stored bits
	ctl_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		bus_req_s ##0 (avs_address_i == `FPEC_CTL_ADDR)
		|=> avs_readdata_o[7:0] == $past({s_q.pin_lvl, s_q.ctl}))
		else $error("control read wrong");

	// select one reads back what it drives
	sel1_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		bus_req_s ##0 (avs_address_i == `FPEC_SEL1_ADDR)
		|=> avs_readdata_o[7:0] == $past(block_sel_one_o))
		else $error("select one read wrong");

	// select two reads back what it drives
	sel2_read_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		bus_req_s ##0 (avs_address_i == `FPEC_SEL2_ADDR)
		|=> avs_readdata_o[7:0] == $past(block_sel_two_o))
		else $error("select two read wrong");

	// ----------------------------------------------------------------
	// gating checks on the control bits and select two
	// ----------------------------------------------------------------
	// unlock sets when the pin allows writes
	unlock_set_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 (wb[`FPEC_B_UNLOCK] && lvl) |=> s_q.ctl[`FPEC_B_UNLOCK])
		else $error("unlock not set");

	// unlock clears on a write of zero
	unlock_clr_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 !wb[`FPEC_B_UNLOCK] |=> !s_q.ctl[`FPEC_B_UNLOCK])
		else $error("unlock not cleared");

	// losing the pin level drops every stored control bit
	pin_clear_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!s_q.pin_lvl |=> s_q.ctl == 7'h00)
		else $error("bits kept without pin level");

	// select two is empty while locked
	sel2_locked_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!s_q.ctl[`FPEC_B_UNLOCK] |-> s_q.sel2 == 8'h00)
		else $error("select two set while locked");

	// erase setup leaves on a write of zero
	wprep_clr_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 !wb[`FPEC_B_WPREP] |=> !s_q.ctl[`FPEC_B_WPREP])
		else $error("erase setup not left");

	// program setup enters when open
	pprep_set_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_open_s ##0 wb[`FPEC_B_PPREP] |=> s_q.ctl[`FPEC_B_PPREP])
		else $error("program setup not entered");

	// erase verify enters when open
	wchk_on_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_open_s ##0 wb[`FPEC_B_WCHK] |=> s_q.ctl[`FPEC_B_WCHK])
		else $error("erase verify not entered");

	// erase verify cancels on a write of zero
	wchk_clr_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 !wb[`FPEC_B_WCHK] |=> !s_q.ctl[`FPEC_B_WCHK])
		else $error("erase verify not left");

	// program verify enters when open
	pchk_on_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_open_s ##0 wb[`FPEC_B_PCHK] |=> s_q.ctl[`FPEC_B_PCHK])
		else $error("program verify not entered");

	// program verify cancels on a write of zero
	pchk_clr_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 !wb[`FPEC_B_PCHK] |=> !s_q.ctl[`FPEC_B_PCHK])
		else $error("program verify not left");

	// erase go only rises out of erase setup with both gates open
	wgo_rise_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		$rose(s_q.ctl[`FPEC_B_WGO]) |-> $past(s_q.ctl[`FPEC_B_WPREP] && lvl && unl))
		else $error("erase go rose while gated");

	// erase go cancels on a write of zero
	wgo_clr_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 !wb[`FPEC_B_WGO] |=> !s_q.ctl[`FPEC_B_WGO])
		else $error("erase go not left");

	// program go never stands without its setup and unlock
	pgo_hold_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		s_q.ctl[`FPEC_B_PGO] |-> s_q.ctl[`FPEC_B_PPREP] && s_q.ctl[`FPEC_B_UNLOCK])
		else $error("program go without setup");

	// program go cancels on a write of zero
	pgo_clr_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 !wb[`FPEC_B_PGO] |=> !s_q.ctl[`FPEC_B_PGO])
		else $error("program go not left");

	// a go bit written together with its setup bit is refused
	same_write_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 !s_q.ctl[`FPEC_B_WPREP] |=> !s_q.ctl[`FPEC_B_WGO])
		else $error("erase go set with setup");

	// the same refusal for the program pair
	same_wr_prog_a: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		ctl_wr_s ##0 !s_q.ctl[`FPEC_B_PPREP] |=> !s_q.ctl[`FPEC_B_PGO])
		else $error("program go set with setup");
endmodule : fpec_top

// ---- sim/fpec_flash_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// far side: the external write-protect pin
// ----------------------------------------
module fpec_flash_model (
	input  wire logic core_clk_i,     // clock
	input  wire logic allow_i,        // bench asks for writes allowed
	output logic      protect_pin_o   // low allows writes
);
	// moves only on an edge so the design never samples a half-changed level
	always @(posedge core_clk_i) begin
		protect_pin_o <= ~allow_i;
	end
endmodule : fpec_flash_model

// ---- sim/test_flash_program_erase_control.sv ----
`timescale 1ns/1ps
module test_flash_program_erase_control;
	logic                  core_clk_i = 1'b0;  // clock
	logic                  sys_rst_i  = 1'b1;  // reset
	logic                  allow      = 1'b0;  // pin low request
	logic                  pin;                // protect pin
	logic [3:0]            addr       = 4'h0;  // bus address
	logic                  rd         = 1'b0;  // read strobe
	logic                  wr         = 1'b0;  // write strobe
	logic [31:0]           wdata      = 32'h0; // write data
	logic [3:0]            be         = 4'hF;  // byte enables
	logic [31:0]           rdq;                // read data pin
	logic [31:0]           rdata;              // captured read data
	logic                  wait_req;           // stall
	fpec_pkg::fpec_flash_s fl;                 // flash controls
	logic [7:0]            sel1;               // block select one
	logic [7:0]            sel2;               // block select two
	int                    miscompares = 0;    // failures
	int                    check_count = 0;    // compares made
	always #2.5 core_clk_i = ~core_clk_i;
	fpec_flash_model far (.core_clk_i(core_clk_i), .allow_i(allow), .protect_pin_o(pin));
	fpec_top dut (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .write_protect_pin_i(pin),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_byteenable_i(be), .avs_readdata_o(rdq), .avs_waitrequest_o(wait_req),
		.flash_ctl_o(fl), .block_sel_one_o(sel1), .block_sel_two_o(sel2));
	// ----------------------------------------
	// bus tasks
	// ----------------------------------------
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk
	// request held until waitrequest is seen low; bounded so a hang is caught
	task access(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		addr  <= a;
		wdata <= d;
		wr    <= w;
		rd    <= !w;
		do @(posedge core_clk_i); while (wait_req !== 1'b0 && ++n < 50);
		if (n >= 50) miscompares++;
		rdata = rdq;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask : access
	task rd_chk(input logic [3:0] a, input logic [31:0] exp);
		access(1'b0, a, 32'h0);
		chk(rdata, exp);
	endtask : rd_chk
	// control write, read back, and flash levels follow bits 5..0
	task wr_rd(input logic [31:0] d, input logic [31:0] exp);
		access(1'b1, 4'h0, d);
		rd_chk(4'h0, exp);
		chk({26'h0, fl}, {26'h0, exp[5:0]});
	endtask : wr_rd
	task settle(input logic a);
		allow <= a;
		repeat (4) @(posedge core_clk_i);
	endtask : settle
	task tally_and_finish();
		if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		settle(1'b0);
		rd_chk(4'h0, 32'h00);
		wr_rd(32'h40, 32'h00);
		settle(1'b1);
		rd_chk(4'h0, 32'h80);
		wr_rd(32'h3F, 32'h80);
		access(1'b1, 4'h1, 32'hFF);
		rd_chk(4'h1, 32'h00);
		wr_rd(32'h40, 32'hC0);
		access(1'b1, 4'h1, 32'h5A);
		access(1'b1, 4'h2, 32'hA5);
		@(posedge core_clk_i);
		chk({sel2, sel1}, 32'hA55A);
		wr_rd(32'h43, 32'hC0);
		for (int b = 2; b < 6; b++) begin
			wr_rd(32'h40 | (1 << b), 32'hC0 | (1 << b));
			wr_rd(32'h40, 32'hC0);
		end
		wr_rd(32'h60, 32'hE0);
		wr_rd(32'h62, 32'hE2);
		wr_rd(32'h60, 32'hE0);
		wr_rd(32'h50, 32'hD0);
		wr_rd(32'h51, 32'hD1);
		wr_rd(32'h40, 32'hC0);
		rd_chk(4'h3, 32'h00);
		settle(1'b0);
		rd_chk(4'h0, 32'h00);
		settle(1'b1);
		wr_rd(32'h40, 32'hC0);
		wr_rd(32'h70, 32'hF0);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		sys_rst_i <= 1'b0;
		rd_chk(4'h0, 32'h80);
		tally_and_finish();
	end
	// watchdog well past the roughly 175 cycles the scenarios need
	initial begin
		#100000;
		miscompares++;
		tally_and_finish();
	end
endmodule : test_flash_program_erase_control
